// ===== core_exec_pkg.sv
/*
 * core_exec_pkg: shared widths, opcodes, fix-up constants and defaults for the
 * instruction execution block.
 * Assumes an upstream decoder that turns program words into core_op_type codes.
 */
package core_exec_pkg;

	// ----------------------------------------------------------------
	// widths and sizes
	// ----------------------------------------------------------------
	localparam int PC_WIDTH = 14;
	localparam int ADDR_WIDTH = 10;
	localparam int STACK_DEPTH = 12;

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam logic [PC_WIDTH-1:0] PC_STEP = 14'h0001;
	localparam logic [PC_WIDTH-1:0] PC_RESET = 14'h0000;
	localparam logic [PC_WIDTH-1:0] IRQ_VECTOR_DEFAULT = 14'h0004;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [8:0] BCD_LOW_FIX = 9'h006;
	localparam logic [8:0] BCD_HIGH_FIX = 9'h060;

	// ----------------------------------------------------------------
	// operations handled here
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_CALL = 5'h01,
		OP_WIPE_MEM = 5'h02,
		OP_CLR_BIT = 5'h03,
		OP_CLR_WDT = 5'h04,
		OP_INVERT_MEM = 5'h05,
		OP_INVERT_TO_ACC = 5'h06,
		OP_BCD_ADJUST = 5'h07,
		OP_DEC = 5'h08,
		OP_DEC_TO_ACC = 5'h09,
		OP_INC = 5'h0a,
		OP_INC_TO_ACC = 5'h0b,
		OP_HALT = 5'h0c,
		OP_GOTO = 5'h0d,
		OP_COPY_TO_ACC = 5'h0e,
		OP_COPY_IMM = 5'h0f,
		OP_COPY_TO_MEM = 5'h10,
		OP_OR_MEM = 5'h11,
		OP_OR_IMM = 5'h12,
		OP_OR_INTO_MEM = 5'h13,
		OP_RET = 5'h14,
		OP_RET_IMM = 5'h15,
		OP_IRQ_EXIT = 5'h16,
		OP_ROTATE_LEFT = 5'h17
	} core_op_type;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_DUMMY = 2'b01,
		ST_HALTED = 2'b10
	} exec_state_type;

endpackage

// ===== hw_stack.sv
/*
 * hw_stack: return address stack held in flip-flops.
 * Assumes push and pop never come together; an overflow wraps and overwrites
 * the oldest entry, an underflow wraps the same way.
 */
`timescale 1ns/1ns
module hw_stack
	import core_exec_pkg::*;
#(
	parameter int WIDTH = PC_WIDTH,
	parameter int DEPTH = STACK_DEPTH
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic push,
	input wire logic pop,
	input wire logic [WIDTH-1:0] push_data,
	output logic [WIDTH-1:0] top
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] entry;
		logic [PTR_W-1:0] ptr;
	} stack_type;

	stack_type cur;
	stack_type next_cur;
	logic [PTR_W-1:0] below;

	// ----------------------------------------------------------------
	// pointer arithmetic, wrapping at the depth
	// ----------------------------------------------------------------
	always_comb
	begin
		below = (cur.ptr == '0) ? PTR_LAST : cur.ptr - PTR_ONE;
		top = cur.entry[below];
		next_cur = cur;
		if (push)
		begin
			next_cur.entry[cur.ptr] = push_data;
			next_cur.ptr = (cur.ptr == PTR_LAST) ? '0 : cur.ptr + PTR_ONE;
		end
		else if (pop)
			next_cur.ptr = below;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			cur <= '0;
		else
			cur <= next_cur;
	end
endmodule

// ===== byte_alu.sv
/*
 * byte_alu: combinational data path for the byte operations of the core.
 * Assumes mem_byte is the addressed data memory byte of the current op.
 */
`timescale 1ns/1ns
module byte_alu
	import core_exec_pkg::*;
(
	input wire core_op_type op,
	input wire logic [7:0] acc,
	input wire logic [7:0] mem_byte,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] imm,
	input wire logic carry,
	input wire logic aux_carry,
	output logic [7:0] result,
	output logic to_mem,
	output logic to_acc,
	output logic upd_zero,
	output logic upd_carry,
	output logic carry_out
);
	logic [8:0] bcd;
	logic fix_low;
	logic fix_high;

	// ----------------------------------------------------------------
	// result selection and which destinations take it
	// ----------------------------------------------------------------
	always_comb
	begin
		fix_low = (acc[3:0] > BCD_DIGIT_MAX) || aux_carry;
		fix_high = (acc[7:4] > BCD_DIGIT_MAX) || carry;
		bcd = {1'b0, acc};
		if (fix_low)
			bcd = bcd + BCD_LOW_FIX;
		if (fix_high)
			bcd = bcd + BCD_HIGH_FIX;
		result = acc;
		to_mem = 1'b0;
		to_acc = 1'b0;
		upd_zero = 1'b0;
		upd_carry = 1'b0;
		carry_out = carry;
		unique case (op)
			OP_WIPE_MEM: begin result = BYTE_ZERO; to_mem = 1'b1; end // RULE_02
			OP_CLR_BIT: begin result = mem_byte & ~(BYTE_ONE << bit_sel); to_mem = 1'b1; end // RULE_03
			OP_INVERT_MEM: begin result = ~mem_byte; to_mem = 1'b1; upd_zero = 1'b1; end // RULE_05
			OP_INVERT_TO_ACC: begin result = ~mem_byte; to_acc = 1'b1; upd_zero = 1'b1; end // RULE_06
			OP_BCD_ADJUST:
			begin
				result = bcd[7:0]; // RULE_07
				to_mem = 1'b1;
				upd_carry = 1'b1;
				carry_out = carry | fix_high | bcd[8]; // RULE_08
			end
			OP_DEC: begin result = mem_byte - BYTE_ONE; to_mem = 1'b1; upd_zero = 1'b1; end // RULE_09
			OP_DEC_TO_ACC: begin result = mem_byte - BYTE_ONE; to_acc = 1'b1; upd_zero = 1'b1; end // RULE_09
			OP_INC: begin result = mem_byte + BYTE_ONE; to_mem = 1'b1; upd_zero = 1'b1; end // RULE_10
			OP_INC_TO_ACC: begin result = mem_byte + BYTE_ONE; to_acc = 1'b1; upd_zero = 1'b1; end // RULE_10
			OP_COPY_TO_ACC: begin result = mem_byte; to_acc = 1'b1; end // RULE_13
			OP_COPY_IMM, OP_RET_IMM: begin result = imm; to_acc = 1'b1; end // RULE_13
			OP_COPY_TO_MEM: begin result = acc; to_mem = 1'b1; end // RULE_13
			OP_OR_MEM: begin result = acc | mem_byte; to_acc = 1'b1; upd_zero = 1'b1; end // RULE_15
			OP_OR_IMM: begin result = acc | imm; to_acc = 1'b1; upd_zero = 1'b1; end // RULE_15
			OP_OR_INTO_MEM: begin result = acc | mem_byte; to_mem = 1'b1; upd_zero = 1'b1; end // RULE_16
			OP_ROTATE_LEFT: begin result = {mem_byte[6:0], mem_byte[7]}; to_mem = 1'b1; end // RULE_21
			default: result = acc;
		endcase
	end
endmodule

// ===== core_exec.sv
/*
 * core_exec: executes calls, returns, clears, complements, decimal adjust,
 * increment/decrement, moves, OR, no-op, halt, jump, rotate left and watchdog
 * clear for an 8-bit core, holding pc, accumulator, flags and stack.
 * Assumes the decoder presents one op with its operands and the addressed memory
 * byte, holding them until instr_ready samples them; memory writes are one cycle.
 */
// Summary of operation
// RULE_01 - call pushes pc plus 1, loads target, two cycles, flags untouched
// RULE_02 - wipe_mem writes zero to the addressed byte, flags untouched
// RULE_03 - bit clear zeroes only the selected bit of the addressed byte
// RULE_04 - watchdog clear resets watchdog and clears timeout and powerdown flags
// RULE_05 - invert_mem stores ones complement in memory and updates zero
// RULE_06 - invert_to_acc puts complement in accumulator, memory kept, zero updated
// RULE_07 - bcd_adjust adds 6 per nibble over 9 or carried, stores to memory
// RULE_08 - bcd_adjust touches only carry, set on decimal overflow
// RULE_09 - decrement to memory or accumulator, zero updated
// RULE_10 - increment to memory or accumulator, zero updated
// RULE_11 - halt stops execution and clock, clears watchdog, sets powerdown, clears timeout
// RULE_12 - goto_addr loads target with one dummy cycle, flags untouched
// RULE_13 - copy_op moves memory, immediate or accumulator without flag changes
// RULE_14 - no-op only advances the program counter
// RULE_15 - OR with memory or immediate into accumulator, zero updated
// RULE_16 - or_into_mem writes accumulator OR byte back to memory, zero updated
// RULE_17 - subroutine_exit pops pc from stack, flags untouched
// RULE_18 - subroutine_exit with immediate also loads accumulator
// RULE_19 - irq_exit pops pc and sets global_irq_enable
// RULE_20 - interrupt pending at irq_exit is serviced before returning to main code
// RULE_21 - rotate_left moves bit 7 into bit 0, stored to memory, flags untouched
// RULE_22 - all other ops of this group finish in one cycle
`timescale 1ns/1ns
module core_exec
	import core_exec_pkg::*;
#(
	parameter logic [PC_WIDTH-1:0] IRQ_VECTOR = IRQ_VECTOR_DEFAULT
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire core_op_type instr_op,
	input wire logic [ADDR_WIDTH-1:0] instr_addr,
	input wire logic [2:0] instr_bit,
	input wire logic [7:0] instr_imm,
	input wire logic [PC_WIDTH-1:0] instr_target,
	input wire logic [7:0] mem_rdata,
	input wire logic flag_load,
	input wire logic flag_carry_in,
	input wire logic flag_aux_carry_in,
	input wire logic flag_zero_in,
	input wire logic irq_pending,
	input wire logic wdt_timeout,
	input wire logic wake,
	output logic instr_ready,
	output logic [PC_WIDTH-1:0] pc,
	output logic [7:0] acc,
	output logic zero_flag,
	output logic carry_flag,
	output logic aux_carry,
	output logic global_irq_enable,
	output logic timeout_flag,
	output logic powerdown_flag,
	output logic watchdog_clear,
	output logic clock_stop,
	output logic irq_ack,
	output logic mem_we,
	output logic [ADDR_WIDTH-1:0] mem_addr,
	output logic [7:0] mem_wdata
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		exec_state_type state;
		logic ready;
		logic [PC_WIDTH-1:0] pc;
		logic [7:0] acc;
		logic zero;
		logic carry;
		logic aux_carry;
		logic gie;
		logic timeout;
		logic powerdown;
		logic wdt_clear;
		logic clock_stop;
		logic irq_ack;
		logic mem_we;
		logic [ADDR_WIDTH-1:0] mem_addr;
		logic [7:0] mem_wdata;
	} exec_type;

	exec_type cur;
	exec_type next_cur;
	logic take;
	logic irq_entry;
	logic push;
	logic pop;
	logic [PC_WIDTH-1:0] push_data;
	logic [PC_WIDTH-1:0] stack_top;
	logic [7:0] alu_result;
	logic alu_to_mem;
	logic alu_to_acc;
	logic alu_upd_zero;
	logic alu_upd_carry;
	logic alu_carry_out;

	// ----------------------------------------------------------------
	// sub-blocks
	// ----------------------------------------------------------------
	hw_stack #(.WIDTH(PC_WIDTH), .DEPTH(STACK_DEPTH)) u_stack (
		.core_clk(core_clk),
		.rst(rst),
		.push(push),
		.pop(pop),
		.push_data(push_data),
		.top(stack_top)
	);

	byte_alu u_alu (
		.op(instr_op),
		.acc(cur.acc),
		.mem_byte(mem_rdata),
		.bit_sel(instr_bit),
		.imm(instr_imm),
		.carry(cur.carry),
		.aux_carry(cur.aux_carry),
		.result(alu_result),
		.to_mem(alu_to_mem),
		.to_acc(alu_to_acc),
		.upd_zero(alu_upd_zero),
		.upd_carry(alu_upd_carry),
		.carry_out(alu_carry_out)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// interrupt entry beats the waiting op, so an irq still pending right after
	// irq_exit is vectored before the main code resumes
	always_comb
	begin
		irq_entry = cur.ready && cur.gie && irq_pending; // RULE_20
		take = cur.ready && instr_valid && !irq_entry;
		push = 1'b0;
		pop = 1'b0;
		push_data = cur.pc + PC_STEP;
		next_cur = cur;
		next_cur.wdt_clear = 1'b0;
		next_cur.irq_ack = 1'b0;
		next_cur.mem_we = 1'b0;
		// flag loads from the rest of the core only land in idle cycles
		if (flag_load && !take)
		begin
			next_cur.carry = flag_carry_in;
			next_cur.aux_carry = flag_aux_carry_in;
			next_cur.zero = flag_zero_in;
		end
		unique case (cur.state)
			ST_RUN:
			begin
				if (irq_entry)
				begin
					push = 1'b1;
					push_data = cur.pc;
					next_cur.pc = IRQ_VECTOR;
					next_cur.gie = 1'b0;
					next_cur.irq_ack = 1'b1;
					next_cur.state = ST_DUMMY;
				end
				else if (take)
				begin
					next_cur.pc = cur.pc + PC_STEP; // RULE_14 RULE_22
					next_cur.mem_addr = instr_addr;
					if (alu_to_mem)
					begin
						next_cur.mem_we = 1'b1;
						next_cur.mem_wdata = alu_result;
					end
					if (alu_to_acc)
						next_cur.acc = alu_result;
					if (alu_upd_zero)
						next_cur.zero = (alu_result == BYTE_ZERO);
					if (alu_upd_carry)
						next_cur.carry = alu_carry_out;
					unique case (instr_op)
						OP_CALL:
						begin
							push = 1'b1; // RULE_01
							next_cur.pc = instr_target;
							next_cur.state = ST_DUMMY;
						end
						OP_GOTO:
						begin
							next_cur.pc = instr_target; // RULE_12
							next_cur.state = ST_DUMMY;
						end
						OP_RET, OP_RET_IMM:
						begin
							pop = 1'b1; // RULE_17 RULE_18
							next_cur.pc = stack_top;
						end
						OP_IRQ_EXIT:
						begin
							pop = 1'b1;
							next_cur.pc = stack_top;
							next_cur.gie = 1'b1; // RULE_19
						end
						OP_CLR_WDT:
						begin
							next_cur.wdt_clear = 1'b1; // RULE_04
							next_cur.timeout = wdt_timeout;
							next_cur.powerdown = 1'b0;
						end
						OP_HALT:
						begin
							next_cur.wdt_clear = 1'b1; // RULE_11
							next_cur.timeout = wdt_timeout;
							next_cur.powerdown = 1'b1;
							next_cur.clock_stop = 1'b1;
							next_cur.state = ST_HALTED;
						end
						default: next_cur.state = ST_RUN;
					endcase
				end
			end
			ST_DUMMY: next_cur.state = ST_RUN;
			ST_HALTED:
			begin
				// pc, accumulator and memory hold until the wake request
				if (wake)
				begin
					next_cur.clock_stop = 1'b0;
					next_cur.state = ST_RUN;
				end
			end
			default: next_cur.state = ST_RUN;
		endcase
		// a watchdog time-out never gets lost under a clear in the same cycle
		if (wdt_timeout)
			next_cur.timeout = 1'b1;
		next_cur.ready = (next_cur.state == ST_RUN);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cur <= '0;
			cur.ready <= 1'b1;
			cur.pc <= PC_RESET;
		end
		else
			cur <= next_cur;
	end

	// outputs straight from the state flops
	assign instr_ready = cur.ready;
	assign pc = cur.pc;
	assign acc = cur.acc;
	assign zero_flag = cur.zero;
	assign carry_flag = cur.carry;
	assign aux_carry = cur.aux_carry;
	assign global_irq_enable = cur.gie;
	assign timeout_flag = cur.timeout;
	assign powerdown_flag = cur.powerdown;
	assign watchdog_clear = cur.wdt_clear;
	assign clock_stop = cur.clock_stop;
	assign irq_ack = cur.irq_ack;
	assign mem_we = cur.mem_we;
	assign mem_addr = cur.mem_addr;
	assign mem_wdata = cur.mem_wdata;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_call;
		take && instr_op == OP_CALL |=> pc == $past(instr_target) && !instr_ready ##1 instr_ready;
	endproperty
	a_call: assert property (p_call) else $error("call target or cycles wrong"); // RULE_01

	property p_wipe;
		take && instr_op == OP_WIPE_MEM |=> mem_we && mem_wdata == BYTE_ZERO && $stable(zero_flag);
	endproperty
	a_wipe: assert property (p_wipe) else $error("wipe did not clear byte"); // RULE_02

	property p_clr_bit;
		take && instr_op == OP_CLR_BIT |=>
			mem_wdata == ($past(mem_rdata) & ~(BYTE_ONE << $past(instr_bit)));
	endproperty
	a_clr_bit: assert property (p_clr_bit) else $error("bit clear wrong"); // RULE_03

	property p_clr_wdt;
		take && instr_op == OP_CLR_WDT && !wdt_timeout |=>
			watchdog_clear && !timeout_flag && !powerdown_flag;
	endproperty
	a_clr_wdt: assert property (p_clr_wdt) else $error("watchdog clear wrong"); // RULE_04

	property p_invert;
		take && instr_op == OP_INVERT_MEM |=> mem_wdata == ~$past(mem_rdata) && zero_flag == (mem_wdata == BYTE_ZERO);
	endproperty
	a_invert: assert property (p_invert) else $error("invert_mem wrong"); // RULE_05

	property p_bcd_flags;
		take && instr_op == OP_BCD_ADJUST |=> $stable(zero_flag) && $stable(aux_carry) && mem_we;
	endproperty
	a_bcd_flags: assert property (p_bcd_flags) else $error("bcd_adjust touched flags"); // RULE_08

	property p_inc_acc;
		take && instr_op == OP_INC_TO_ACC |=> acc == 8'($past(mem_rdata) + BYTE_ONE) && !mem_we;
	endproperty
	a_inc_acc: assert property (p_inc_acc) else $error("increment_to_acc wrong"); // RULE_10

	property p_halt;
		take && instr_op == OP_HALT |=> clock_stop && powerdown_flag && watchdog_clear && !instr_ready;
	endproperty
	a_halt: assert property (p_halt) else $error("halt entry wrong"); // RULE_11

	property p_ret;
		take && instr_op == OP_RET |=> pc == $past(stack_top) && instr_ready;
	endproperty
	a_ret: assert property (p_ret) else $error("return address wrong"); // RULE_17

	property p_irq_exit;
		take && instr_op == OP_IRQ_EXIT ##1 irq_pending |-> ##1 irq_ack && pc == IRQ_VECTOR;
	endproperty
	a_irq_exit: assert property (p_irq_exit) else $error("pending irq not serviced"); // RULE_20

	property p_nop;
		take && instr_op == OP_NOP |=> instr_ready && pc == $past(pc) + PC_STEP && !mem_we;
	endproperty
	a_nop: assert property (p_nop) else $error("nop changed state"); // RULE_22
endmodule

// ===== tb_top.sv
/*
 * tb_top: self-checking bench for core_exec; runs every op of the group and
 * judges pc, accumulator, flags, the memory write port and power-down outputs.
 * Assumes one 125 MHz clock, inputs changed on the falling edge, no partner.
 */
`timescale 1ns/1ns
module tb_top
	import core_exec_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic core_clk, rst, instr_valid, flag_load, flag_carry_in, flag_aux_carry_in;
	logic flag_zero_in, irq_pending, wdt_timeout, wake, instr_ready, zero_flag;
	logic carry_flag, aux_carry, global_irq_enable, timeout_flag, powerdown_flag;
	logic watchdog_clear, clock_stop, irq_ack, mem_we;
	core_op_type instr_op;
	logic [ADDR_WIDTH-1:0] instr_addr, mem_addr;
	logic [2:0] instr_bit;
	logic [7:0] instr_imm, mem_rdata, acc, mem_wdata;
	logic [PC_WIDTH-1:0] instr_target, pc, exp_pc;
	logic exp_z;
	int err_total, tests_run;

	core_exec i_dut (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
		.instr_op(instr_op), .instr_addr(instr_addr), .instr_bit(instr_bit),
		.instr_imm(instr_imm), .instr_target(instr_target), .mem_rdata(mem_rdata),
		.flag_load(flag_load), .flag_carry_in(flag_carry_in),
		.flag_aux_carry_in(flag_aux_carry_in), .flag_zero_in(flag_zero_in),
		.irq_pending(irq_pending), .wdt_timeout(wdt_timeout), .wake(wake),
		.instr_ready(instr_ready), .pc(pc), .acc(acc), .zero_flag(zero_flag),
		.carry_flag(carry_flag), .aux_carry(aux_carry),
		.global_irq_enable(global_irq_enable), .timeout_flag(timeout_flag),
		.powerdown_flag(powerdown_flag), .watchdog_clear(watchdog_clear),
		.clock_stop(clock_stop), .irq_ack(irq_ack), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata));

	// 8 ns period
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// presents an op at a falling edge and returns at the falling edge after it is
	// taken; valid stays high so ops chain back to back, callers drop it via idle
	task automatic issue(input core_op_type op, input logic [7:0] rd, input logic [7:0] imm);
		int n;
		instr_op = op;
		mem_rdata = rd;
		instr_imm = imm;
		instr_valid = 1'b1;
		n = 0;
		while (!(instr_ready === 1'b1 && !(global_irq_enable === 1'b1 && irq_pending)))
		begin
			@(negedge core_clk);
			n++;
			if (n > 20)
			begin
				check(16'h0000, 16'h0001, "op never taken");
				stop_test();
			end
		end
		@(negedge core_clk);
	endtask

	task automatic idle();
		instr_valid = 1'b0;
		@(negedge core_clk);
	endtask

	// we: a memory write of val is expected, otherwise the accumulator holds val
	task automatic byte_op(input core_op_type op, input logic [7:0] rd, input logic [7:0] imm,
		input logic we, input logic [7:0] val, input logic zu);
		logic [7:0] a0;
		a0 = acc;
		issue(op, rd, imm);
		exp_pc = exp_pc + PC_STEP;
		if (zu)
			exp_z = (val == 8'h00);
		check(16'(instr_ready), 16'h0001, "ready after op");
		check(16'(mem_we), 16'(we), "write strobe");
		if (we)
		begin
			check(16'(mem_wdata), 16'(val), "write data");
			check(16'(mem_addr), 16'(instr_addr), "write address");
			check(16'(acc), 16'(a0), "accumulator kept");
		end
		else
			check(16'(acc), 16'(val), "accumulator");
		check(16'(zero_flag), 16'(exp_z), "zero flag");
		check(16'(pc), 16'(exp_pc), "pc");
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// back-to-back byte ops; zero flag tracked only where an op may change it
	task automatic t_bytes();
		instr_addr = 10'h3ff;
		byte_op(OP_COPY_IMM, 8'h00, 8'h5a, 1'b0, 8'h5a, 1'b0);
		byte_op(OP_OR_IMM, 8'h00, 8'h00, 1'b0, 8'h5a, 1'b1);
		byte_op(OP_INC_TO_ACC, 8'hff, 8'h00, 1'b0, 8'h00, 1'b1);
		byte_op(OP_WIPE_MEM, 8'h37, 8'h00, 1'b1, 8'h00, 1'b0);
		byte_op(OP_COPY_TO_ACC, 8'h81, 8'h00, 1'b0, 8'h81, 1'b0);
		byte_op(OP_OR_MEM, 8'h24, 8'h00, 1'b0, 8'ha5, 1'b1);
		byte_op(OP_OR_INTO_MEM, 8'h00, 8'h00, 1'b1, 8'ha5, 1'b1);
		instr_addr = 10'h155;
		byte_op(OP_INVERT_MEM, 8'hff, 8'h00, 1'b1, 8'h00, 1'b1);
		byte_op(OP_INVERT_TO_ACC, 8'h0f, 8'h00, 1'b0, 8'hf0, 1'b1);
		byte_op(OP_DEC, 8'h01, 8'h00, 1'b1, 8'h00, 1'b1);
		byte_op(OP_DEC_TO_ACC, 8'h00, 8'h00, 1'b0, 8'hff, 1'b1);
		byte_op(OP_INC, 8'hff, 8'h00, 1'b1, 8'h00, 1'b1);
		byte_op(OP_ROTATE_LEFT, 8'h81, 8'h00, 1'b1, 8'h03, 1'b0);
		byte_op(OP_COPY_TO_MEM, 8'h00, 8'h00, 1'b1, 8'hff, 1'b0);
		byte_op(OP_NOP, 8'h00, 8'h00, 1'b0, 8'hff, 1'b0);
		instr_bit = 3'h7;
		byte_op(OP_CLR_BIT, 8'hff, 8'h00, 1'b1, 8'h7f, 1'b0);
		instr_bit = 3'h0;
		byte_op(OP_CLR_BIT, 8'h01, 8'h00, 1'b1, 8'h00, 1'b0);
		idle();
		$display("test bytes done");
	endtask

	// loads acc and both carries, then adjusts; only carry may move
	task automatic bcd(input logic [7:0] a, input logic c, input logic ac,
		input logic [7:0] res, input logic cout);
		byte_op(OP_COPY_IMM, 8'h00, a, 1'b0, a, 1'b0);
		instr_valid = 1'b0;
		flag_load = 1'b1;
		flag_carry_in = c;
		flag_aux_carry_in = ac;
		flag_zero_in = exp_z;
		@(negedge core_clk);
		flag_load = 1'b0;
		byte_op(OP_BCD_ADJUST, 8'h00, 8'h00, 1'b1, res, 1'b0);
		check(16'(carry_flag), 16'(cout), "decimal carry");
		check(16'(aux_carry), 16'(ac), "aux carry kept");
		idle();
	endtask

	task automatic t_bcd();
		bcd(8'h45, 1'b0, 1'b0, 8'h45, 1'b0);
		bcd(8'h15, 1'b0, 1'b1, 8'h1b, 1'b0);
		bcd(8'ha3, 1'b0, 1'b0, 8'h03, 1'b1);
		bcd(8'h12, 1'b1, 1'b0, 8'h72, 1'b1);
		bcd(8'h2a, 1'b1, 1'b0, 8'h90, 1'b1);
		$display("test bcd done");
	endtask

	// nested calls, both returns, then a jump with its dummy cycle
	task automatic t_flow();
		logic [PC_WIDTH-1:0] r0;
		r0 = exp_pc + PC_STEP;
		instr_target = 14'h0100;
		issue(OP_CALL, 8'h00, 8'h00);
		check(16'(pc), 16'h0100, "call target");
		check(16'(instr_ready), 16'h0000, "call second cycle");
		check(16'(zero_flag), 16'(exp_z), "call flags");
		instr_target = 14'h0200;
		issue(OP_CALL, 8'h00, 8'h00);
		check(16'(pc), 16'h0200, "nested call");
		issue(OP_RET_IMM, 8'h00, 8'h3c);
		check(16'(pc), 16'h0101, "return with data pc");
		check(16'(acc), 16'h003c, "return with data acc");
		issue(OP_RET, 8'h00, 8'h00);
		check(16'(pc), 16'(r0), "return pc");
		check(16'(zero_flag), 16'(exp_z), "return flags");
		instr_target = 14'h2abc;
		issue(OP_GOTO, 8'h00, 8'h00);
		check(16'(pc), 16'h2abc, "jump target");
		check(16'(instr_ready), 16'h0000, "jump dummy");
		idle();
		check(16'(instr_ready), 16'h0001, "jump two cycles");
		exp_pc = 14'h2abc;
		$display("test flow done");
	endtask

	// return from interrupt with another one waiting, then a second irq_exit back to main code
	task automatic t_irq();
		logic [PC_WIDTH-1:0] r0;
		r0 = exp_pc + PC_STEP;
		instr_target = 14'h0050;
		irq_pending = 1'b1;
		issue(OP_CALL, 8'h00, 8'h00);
		check(16'(irq_ack), 16'h0000, "no entry while disabled");
		issue(OP_IRQ_EXIT, 8'h00, 8'h00);
		check(16'(pc), 16'(r0), "irq exit pc");
		check(16'(global_irq_enable), 16'h0001, "irq exit enable");
		idle();
		check(16'(irq_ack), 16'h0001, "pending serviced");
		check(16'(pc), 16'(IRQ_VECTOR_DEFAULT), "vector");
		irq_pending = 1'b0;
		issue(OP_IRQ_EXIT, 8'h00, 8'h00);
		check(16'(pc), 16'(r0), "back to main");
		check(16'(global_irq_enable), 16'h0001, "enable again");
		idle();
		exp_pc = r0;
		$display("test irq done");
	endtask

	// halt, stay halted, wake, then watchdog clear after a timeout
	task automatic t_power();
		wdt_timeout = 1'b1;
		@(negedge core_clk);
		wdt_timeout = 1'b0;
		check(16'(timeout_flag), 16'h0001, "timeout set");
		issue(OP_HALT, 8'h00, 8'h00);
		check(16'(clock_stop), 16'h0001, "clock stopped");
		check(16'(powerdown_flag), 16'h0001, "powerdown set");
		check(16'(timeout_flag), 16'h0000, "timeout cleared");
		check(16'(watchdog_clear), 16'h0001, "watchdog cleared");
		check(16'(pc), 16'(exp_pc + PC_STEP), "halt pc");
		exp_pc = exp_pc + PC_STEP;
		instr_valid = 1'b0;
		repeat (3) @(negedge core_clk);
		check(16'(instr_ready), 16'h0000, "halted refuses ops");
		check(16'(clock_stop), 16'h0001, "still stopped");
		// the last accumulator load was the return with data in the flow test
		check(16'(acc), 16'h003c, "acc retained");
		wake = 1'b1;
		@(negedge core_clk);
		wake = 1'b0;
		check(16'(clock_stop), 16'h0000, "woken");
		check(16'(instr_ready), 16'h0001, "ready after wake");
		wdt_timeout = 1'b1;
		@(negedge core_clk);
		wdt_timeout = 1'b0;
		issue(OP_CLR_WDT, 8'h00, 8'h00);
		check(16'(timeout_flag), 16'h0000, "clear timeout");
		check(16'(powerdown_flag), 16'h0000, "clear powerdown");
		check(16'(watchdog_clear), 16'h0001, "clear watchdog");
		idle();
		check(16'(watchdog_clear), 16'h0000, "clear pulse ends");
		$display("test power done");
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		err_total = 0;
		tests_run = 0;
		rst = 1'b1;
		instr_valid = 1'b0;
		instr_op = OP_NOP;
		instr_addr = '0;
		instr_bit = 3'h0;
		instr_imm = 8'h00;
		instr_target = '0;
		mem_rdata = 8'h00;
		flag_load = 1'b0;
		flag_carry_in = 1'b0;
		flag_aux_carry_in = 1'b0;
		flag_zero_in = 1'b0;
		irq_pending = 1'b0;
		wdt_timeout = 1'b0;
		wake = 1'b0;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		check(16'(pc), 16'(PC_RESET), "reset pc");
		check(16'(instr_ready), 16'h0001, "reset ready");
		check(16'(acc), 16'h0000, "reset acc");
		exp_pc = PC_RESET;
		exp_z = 1'b0;
		$display("test reset done");
		t_bytes();
		t_bcd();
		t_flow();
		t_irq();
		t_power();
		stop_test();
	end
endmodule
